// file: inc/iad_regs.svh
// Address map, region bounds, bank layout and reset values of the indirect address decoder.
// Behaviour
// - Indirect port accesses location held in pointer.
// - Pointer at indirect port: read zero, no write.
// - Pointer is high byte joined to low byte.
// - 0x0000-0x0FFF addresses data memory absolutely.
// - 0x2000-0x29AF walks banked RAM blocks linearly.
// - Unimplemented locations read back as 0x00.
// - Linear region skips the common bytes.
// - High byte 0x70 maps EEPROM by low byte.
// - Writes to the EEPROM window are dropped.
// - EEPROM window reads take one extra cycle.
// - Pointer bit 15 selects flash word address.
// - Flash reads return only low eight bits.
// - Writes to the flash window are dropped.
// - Flash window accesses take one extra cycle.
`ifndef IAD_REGS_SVH
`define IAD_REGS_SVH

// ----------------------------------------------------------------------------
// Region bounds
// ----------------------------------------------------------------------------
`define IAD_TRAD_LAST 16'h0FFF
`define IAD_LIN_FIRST 16'h2000
`define IAD_LIN_LAST 16'h29AF
`define IAD_EE_HIGH 8'h70
`define IAD_FLASH_BIT 15

// ----------------------------------------------------------------------------
// Bank layout
// ----------------------------------------------------------------------------
`define IAD_PORT_OFS_LAST 7'h01
`define IAD_GPR_BLOCK 12'h0050
`define IAD_GPR_BASE 7'h20
`define IAD_BANK_SHIFT 7
`define IAD_GPR_BANKS 5'h0C
`define IAD_FLASH_WORDS 15'h2000

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define IAD_RDATA_RST 8'h00
`define IAD_ZERO_BYTE 8'h00

`endif

// file: inc/iad_pkg.sv
// Types shared by the indirect address decoder modules.
package iad_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_EXTRA,
    ST_CAPTURE
  } iad_state_t;

  typedef enum logic [1:0] {
    SRC_ZERO,
    SRC_RAM,
    SRC_EE,
    SRC_FLASH
  } iad_src_t;

  typedef struct packed {
    iad_state_t state;
    iad_src_t src;
    logic slow;
    logic [11:0] ram_addr;
    logic [7:0] ram_wdata;
    logic ram_rd;
    logic ram_wr;
    logic [7:0] ee_addr;
    logic ee_rd;
    logic [14:0] fl_addr;
    logic fl_rd;
    logic [7:0] rdata;
    logic done;
  } iad_core_t;

endpackage

// file: logic/iad_lin_map.sv
// Maps a linear-region pointer onto the absolute address of a banked RAM byte.
`timescale 1ns/10ps
`default_nettype none
`include "iad_regs.svh"

module iad_lin_map (
  input wire logic [15:0] pointer,
  output logic [11:0] abs_addr,
  output logic [4:0] bank
);
  import iad_pkg::*;

  logic [11:0] lin;
  logic [11:0] quot;
  logic [11:0] rem;

  // Each bank contributes only its banked block; common bytes never appear.
  always_comb begin
    lin = 12'(pointer - `IAD_LIN_FIRST);
    quot = lin / `IAD_GPR_BLOCK;
    rem = 12'(lin - 12'(quot * `IAD_GPR_BLOCK));
    bank = quot[4:0];
    abs_addr = {quot[4:0], 7'(rem[6:0] + `IAD_GPR_BASE)};
  end

endmodule // iad_lin_map
`default_nettype wire

// file: logic/iad_decoder.sv
// Indirect data port decoder: pointer region decode and memory access sequencing.
`timescale 1ns/10ps
`default_nettype none
`include "iad_regs.svh"

module iad_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [7:0] pointer_high_byte,
  input wire logic [7:0] pointer_low_byte,
  input wire logic [7:0] req_wdata,
  output logic rsp_done,
  output logic [7:0] rsp_rdata,
  output logic [11:0] ram_addr,
  output logic ram_rd,
  output logic ram_wr,
  output logic [7:0] ram_wdata,
  input wire logic [7:0] ram_rdata,
  output logic [7:0] ee_addr,
  output logic ee_rd,
  input wire logic [7:0] ee_rdata,
  output logic [14:0] fl_addr,
  output logic fl_rd,
  input wire logic [13:0] fl_rdata
);
  import iad_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  iad_core_t core;
  iad_core_t next_core;

  logic [15:0] file_select_pointer;
  logic [11:0] lin_addr;
  logic [4:0] lin_bank;
  logic take;

  // Decode results for the pointer presented this cycle.
  iad_src_t dec_src;
  logic dec_slow;
  logic [11:0] dec_ram_addr;

  // --------------------------------------------------------------------------
  // Pointer assembly and linear mapping
  // --------------------------------------------------------------------------
  assign file_select_pointer = {pointer_high_byte, pointer_low_byte};

  iad_lin_map u_lin_map (
    .pointer(file_select_pointer),
    .abs_addr(lin_addr),
    .bank(lin_bank)
  );

  assign req_ready = (core.state == ST_IDLE);
  assign take = req_valid && req_ready;

  // --------------------------------------------------------------------------
  // Region decode
  // --------------------------------------------------------------------------
  // The flash bit is tested first because it covers the whole upper half.
  always_comb begin
    dec_src = SRC_ZERO;
    dec_slow = 1'b0;
    dec_ram_addr = 12'h0000;
    if (file_select_pointer[`IAD_FLASH_BIT]) begin
      // Flash accesses cost an extra cycle whether read or write.
      dec_slow = 1'b1;
      if (file_select_pointer[14:0] < `IAD_FLASH_WORDS) begin
        dec_src = SRC_FLASH;
      end else begin
        dec_src = SRC_ZERO;
      end
    end else if (pointer_high_byte == `IAD_EE_HIGH) begin
      dec_src = SRC_EE;
      dec_slow = !req_write;
    end else if (file_select_pointer <= `IAD_TRAD_LAST) begin
      dec_ram_addr = file_select_pointer[11:0];
      if (file_select_pointer[6:0] <= `IAD_PORT_OFS_LAST) begin
        dec_src = SRC_ZERO;
      end else begin
        dec_src = SRC_RAM;
      end
    end else if ((file_select_pointer >= `IAD_LIN_FIRST) &&
                 (file_select_pointer <= `IAD_LIN_LAST)) begin
      dec_ram_addr = lin_addr;
      if (lin_bank < `IAD_GPR_BANKS) begin
        dec_src = SRC_RAM;
      end else begin
        dec_src = SRC_ZERO;
      end
    end else begin
      dec_src = SRC_ZERO;
    end
  end

  // --------------------------------------------------------------------------
  // Access sequencer
  // --------------------------------------------------------------------------
  // Strobes last exactly the ISSUE cycle; memories answer on the next cycle
  // and hold their read data until their next strobe.
  always_comb begin
    next_core = core;
    next_core.ram_rd = 1'b0;
    next_core.ram_wr = 1'b0;
    next_core.ee_rd = 1'b0;
    next_core.fl_rd = 1'b0;
    next_core.done = 1'b0;
    case (core.state)
      ST_IDLE: begin
        if (take) begin
          next_core.state = ST_ISSUE;
          next_core.src = dec_src;
          next_core.slow = dec_slow;
          next_core.ram_addr = dec_ram_addr;
          next_core.ram_wdata = req_wdata;
          next_core.ee_addr = pointer_low_byte;
          next_core.fl_addr = file_select_pointer[14:0];
          // Only RAM ever sees a write; the port itself holds nothing.
          next_core.ram_wr = req_write && (dec_src == SRC_RAM);
          next_core.ram_rd = !req_write && (dec_src == SRC_RAM);
          // Nonvolatile windows are read only; writes issue no strobe.
          next_core.ee_rd = !req_write && (dec_src == SRC_EE);
          next_core.fl_rd = !req_write && (dec_src == SRC_FLASH);
        end
      end
      ST_ISSUE: begin
        if (core.slow) begin
          next_core.state = ST_EXTRA;
        end else begin
          next_core.state = ST_CAPTURE;
        end
      end
      ST_EXTRA: begin
        next_core.state = ST_CAPTURE;
      end
      ST_CAPTURE: begin
        next_core.state = ST_IDLE;
        next_core.done = 1'b1;
        case (core.src)
          SRC_RAM: begin
            next_core.rdata = ram_rdata;
          end
          SRC_EE: begin
            next_core.rdata = ee_rdata;
          end
          SRC_FLASH: begin
            next_core.rdata = fl_rdata[7:0];
          end
          default: begin
            next_core.rdata = `IAD_ZERO_BYTE;
          end
        endcase
      end
      default: begin
        next_core.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      core <= '0;
      core.state <= ST_IDLE;
      core.src <= SRC_ZERO;
      core.rdata <= `IAD_RDATA_RST;
    end else begin
      core <= next_core;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign rsp_done = core.done;
  assign rsp_rdata = core.rdata;
  assign ram_addr = core.ram_addr;
  assign ram_rd = core.ram_rd;
  assign ram_wr = core.ram_wr;
  assign ram_wdata = core.ram_wdata;
  assign ee_addr = core.ee_addr;
  assign ee_rd = core.ee_rd;
  assign fl_addr = core.fl_addr;
  assign fl_rd = core.fl_rd;

endmodule // iad_decoder
`default_nettype wire

// file: sim/iad_sva.sv
// Port assertions for the indirect address decoder.
`timescale 1ns/10ps
`default_nettype none
module iad_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic [7:0] pointer_high_byte,
  input wire logic [7:0] pointer_low_byte,
  input wire logic [7:0] req_wdata,
  input wire logic rsp_done,
  input wire logic [7:0] rsp_rdata,
  input wire logic [11:0] ram_addr,
  input wire logic ram_rd,
  input wire logic ram_wr,
  input wire logic [7:0] ram_wdata,
  input wire logic [7:0] ee_addr,
  input wire logic ee_rd,
  input wire logic [14:0] fl_addr,
  input wire logic fl_rd,
  input wire logic [13:0] fl_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] p;
  logic [15:0] lin;
  logic [11:0] la;
  logic tk;
  logic rd;
  logic trad;
  logic zr;
  assign p = {pointer_high_byte, pointer_low_byte};
  assign lin = p - 16'h2000;
  // Expected absolute address: linear bytes walk 80-byte blocks at offset 0x20 of each bank.
  assign la = p[13] ? 12'((lin / 16'd80) * 16'd128 + 16'd32 + lin % 16'd80) : p[11:0];
  assign tk = req_valid && req_ready;
  assign rd = tk && !req_write;
  assign trad = p <= 16'h0FFF && p[6:0] > 7'h01;
  assign zr = (p > 16'h0FFF && p < 16'h2000) || (p >= 16'h23C0 && p < 16'h7000) ||
    (p > 16'h70FF && !p[15]);
  sequence s_idle; !ram_rd && !ram_wr && !ee_rd && !fl_rd; endsequence
  sequence s_norm; ##2 rsp_done; endsequence
  sequence s_slow; ##3 rsp_done; endsequence
  ram_read_a: assert property (rd && trad |=> ram_rd && ram_addr == $past(la) ##0 s_norm)
    else $error("ram read not issued");
  ram_write_a: assert property (tk && req_write && trad |=> ram_wr &&
    ram_wdata == $past(req_wdata) && ram_addr == $past(la)) else $error("ram write wrong");
  port_self_a: assert property (rd && p <= 16'h0FFF && p[6:0] <= 7'h01 |=>
    s_idle ##0 s_norm ##0 rsp_rdata == 8'h00) else $error("port self read not zero");
  port_write_a: assert property (tk && req_write && p <= 16'h0FFF && p[6:0] <= 7'h01 |=>
    s_idle ##0 s_norm) else $error("port self write not dropped");
  lin_map_a: assert property (rd && p >= 16'h2000 && p < 16'h23C0 |=>
    ram_rd && ram_addr == $past(la)) else $error("linear map wrong");
  unimp_zero_a: assert property (rd && zr |=> s_idle ##0 s_norm ##0 rsp_rdata == 8'h00)
    else $error("unimplemented read not zero");
  ee_read_a: assert property (rd && pointer_high_byte == 8'h70 |=> ee_rd &&
    ee_addr == $past(pointer_low_byte) ##0 s_slow) else $error("eeprom read wrong");
  ee_write_a: assert property (tk && req_write && pointer_high_byte == 8'h70 |=>
    s_idle ##0 s_norm) else $error("eeprom write not dropped");
  fl_read_a: assert property (rd && p[15] && p[14:0] < 15'h2000 |=> fl_rd &&
    {1'b1, fl_addr} == $past(p) ##0 s_slow ##0 rsp_rdata == fl_rdata[7:0])
    else $error("flash read wrong");
  fl_write_a: assert property (tk && req_write && p[15] |=> s_idle ##0 s_slow)
    else $error("flash write wrong");
endmodule // iad_sva
bind iad_decoder iad_sva iad_sva_inst (
  .clk(clk),
  .rst(rst),
  .req_valid(req_valid),
  .req_ready(req_ready),
  .req_write(req_write),
  .pointer_high_byte(pointer_high_byte),
  .pointer_low_byte(pointer_low_byte),
  .req_wdata(req_wdata),
  .rsp_done(rsp_done),
  .rsp_rdata(rsp_rdata),
  .ram_addr(ram_addr),
  .ram_rd(ram_rd),
  .ram_wr(ram_wr),
  .ram_wdata(ram_wdata),
  .ee_addr(ee_addr),
  .ee_rd(ee_rd),
  .fl_addr(fl_addr),
  .fl_rd(fl_rd),
  .fl_rdata(fl_rdata)
);
`default_nettype wire

// file: sim/iad_mem_model.sv
// Data memory array and computed EEPROM and flash contents behind the decoder.
`timescale 1ns/10ps
`default_nettype none
module iad_mem_model (
  input wire logic clk,
  input wire logic [11:0] ram_addr,
  input wire logic ram_rd,
  input wire logic ram_wr,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata,
  input wire logic [7:0] ee_addr,
  input wire logic ee_rd,
  output logic [7:0] ee_rdata,
  input wire logic [14:0] fl_addr,
  input wire logic fl_rd,
  output logic [13:0] fl_rdata
);
  logic [7:0] ram [4096];
  initial begin
    for (int i = 0; i < 4096; i++) ram[i] = i[7:0];
    ram_rdata = 8'h00;
    ee_rdata = 8'h00;
    fl_rdata = 14'h0000;
  end
  // Read data lands the cycle after a strobe and holds until the next one.
  always @(posedge clk) begin
    if (ram_wr) ram[ram_addr] <= ram_wdata;
    if (ram_rd) ram_rdata <= ram[ram_addr];
    if (ee_rd) ee_rdata <= ee_addr ^ 8'hC3;
    if (fl_rd) fl_rdata <= {6'h2A, fl_addr[7:0] ^ 8'h5A};
  end
endmodule // iad_mem_model
`default_nettype wire

// file: sim/test_indirect_address_decoder.sv
// Self-checking testbench for the indirect address decoder.
`timescale 1ns/10ps
`default_nettype none
module test_indirect_address_decoder;
  logic clk = 0, rst = 1, req_valid = 0, req_write = 0;
  logic [7:0] pointer_high_byte = 0, pointer_low_byte = 0, req_wdata = 0;
  logic req_ready, rsp_done, ram_rd, ram_wr, ee_rd, fl_rd;
  logic [7:0] rsp_rdata, ram_wdata, ram_rdata, ee_addr, ee_rdata;
  logic [11:0] ram_addr;
  logic [14:0] fl_addr;
  logic [13:0] fl_rdata;
  int errors = 0, comparisons = 0, cyc = 0;
  iad_decoder iad_decoder_inst (
    .clk(clk),
    .rst(rst),
    .req_valid(req_valid),
    .req_ready(req_ready),
    .req_write(req_write),
    .pointer_high_byte(pointer_high_byte),
    .pointer_low_byte(pointer_low_byte),
    .req_wdata(req_wdata),
    .rsp_done(rsp_done),
    .rsp_rdata(rsp_rdata),
    .ram_addr(ram_addr),
    .ram_rd(ram_rd),
    .ram_wr(ram_wr),
    .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata),
    .ee_addr(ee_addr),
    .ee_rd(ee_rd),
    .ee_rdata(ee_rdata),
    .fl_addr(fl_addr),
    .fl_rd(fl_rd),
    .fl_rdata(fl_rdata)
  );
  iad_mem_model iad_mem_model_inst (
    .clk(clk),
    .ram_addr(ram_addr),
    .ram_rd(ram_rd),
    .ram_wr(ram_wr),
    .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata),
    .ee_addr(ee_addr),
    .ee_rd(ee_rd),
    .ee_rdata(ee_rdata),
    .fl_addr(fl_addr),
    .fl_rd(fl_rd),
    .fl_rdata(fl_rdata)
  );
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      summarize();
    end
  end
  task automatic chk(string name, logic [7:0] got, logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic acc(logic w, logic [15:0] p, logic [7:0] wd, logic [7:0] lat, logic [7:0] exp);
    logic [7:0] n;
    @(negedge clk);
    req_valid = 1;
    req_write = w;
    {pointer_high_byte, pointer_low_byte} = p;
    req_wdata = wd;
    @(posedge clk);
    @(negedge clk);
    req_valid = 0;
    chk("ready_busy", {7'h00, req_ready}, 8'h00);
    // The count names the edge, counting the take edge as the first, at which done is sampled high.
    n = 1;
    while (rsp_done !== 1'b1 && n < 8'h09) begin
      @(posedge clk);
      #1 n++;
    end
    chk("latency", n, lat);
    if (!w) chk("rdata", rsp_rdata, exp);
  endtask
  task t_trad;
    acc(1, 16'h0123, 8'hA5, 8'h03, 8'h00);
    acc(0, 16'h0123, 8'h00, 8'h03, 8'hA5);
    acc(0, 16'h0FFF, 8'h00, 8'h03, 8'hFF);
  endtask
  task t_port;
    acc(1, 16'h0081, 8'h77, 8'h03, 8'h00);
    acc(0, 16'h0081, 8'h00, 8'h03, 8'h00);
    acc(0, 16'h0F80, 8'h00, 8'h03, 8'h00);
    chk("ram_081", iad_mem_model_inst.ram[12'h081], 8'h81);
  endtask
  task t_reset;
    @(negedge clk);
    rst = 1;
    @(posedge clk);
    @(negedge clk);
    chk("ready_rst", {7'h00, req_ready}, 8'h01);
    chk("rdata_rst", rsp_rdata, 8'h00);
    rst = 0;
  endtask
  task t_lin;
    acc(1, 16'h2050, 8'h3C, 8'h03, 8'h00);
    acc(0, 16'h00A0, 8'h00, 8'h03, 8'h3C);
    acc(0, 16'h204F, 8'h00, 8'h03, 8'h6F);
    acc(0, 16'h23BF, 8'h00, 8'h03, 8'hEF);
    acc(0, 16'h23C0, 8'h00, 8'h03, 8'h00);
  endtask
  task t_ee;
    acc(0, 16'h70FF, 8'h00, 8'h04, 8'h3C);
    acc(0, 16'h7000, 8'h00, 8'h04, 8'hC3);
    acc(1, 16'h7010, 8'h99, 8'h03, 8'h00);
    acc(0, 16'h0010, 8'h00, 8'h03, 8'h10);
  endtask
  task t_fl;
    acc(0, 16'h8123, 8'h00, 8'h04, 8'h79);
    acc(0, 16'h9FFF, 8'h00, 8'h04, 8'hA5);
    acc(1, 16'h8023, 8'h11, 8'h04, 8'h00);
    acc(0, 16'h0023, 8'h00, 8'h03, 8'h23);
    acc(0, 16'hA000, 8'h00, 8'h04, 8'h00);
  endtask
  task t_unimp;
    acc(0, 16'h1234, 8'h00, 8'h03, 8'h00);
    acc(0, 16'h7100, 8'h00, 8'h03, 8'h00);
    acc(1, 16'h1234, 8'h66, 8'h03, 8'h00);
    acc(0, 16'h0234, 8'h00, 8'h03, 8'h34);
  endtask
  task summarize;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 0;
    t_trad();
    t_reset();
    t_port();
    t_lin();
    t_ee();
    t_fl();
    t_unimp();
    summarize();
  end
endmodule // test_indirect_address_decoder
`default_nettype wire
